/* rtl/config_decode_defs.svh */
// Purpose: Constants for the configuration word decoder
// Assumes: 24-bit configuration words, upper byte unimplemented
// Notes:   Bit positions, word indices and reset values
`ifndef CONFIG_DECODE_DEFS_SVH
`define CONFIG_DECODE_DEFS_SVH

`define CW_WIDTH            24
`define CW_UPPER_ONES       8'hff
`define CW_ERASED           24'hffffff
// Word indices in the packed block at top of program memory
`define CW_IDX_OSC          2'h1
`define CW_IDX_PROT         2'h2
`define CW_IDX_DSLP         2'h3
`define CW_IDX_LAST         2'h3
// Oscillator word fields
`define OSC_TWO_SPEED_BIT   15
`define OSC_VBAT_BOR_BIT    14
`define OSC_WDT_MUX_BIT     13
`define OSC_CMP_REF_BIT     12
`define OSC_ADC_REF_BIT     11
`define OSC_INIT_HI         10
`define OSC_INIT_LO         8
`define OSC_CKSM_HI         7
`define OSC_CKSM_LO         6
`define OSC_PIN_FUNC_BIT    5
`define OSC_WDT_SRC_HI      4
`define OSC_WDT_SRC_LO      3
`define OSC_PRI_HI          1
`define OSC_PRI_LO          0
// Protection word fields
`define PROT_END_PAGE_BIT   15
`define PROT_CFG_PAGE_BIT   14
`define PROT_DISABLE_BIT    13
`define PROT_BOR_EN_BIT     12
`define PROT_WIN_HI         10
`define PROT_WIN_LO         9
`define PROT_SECONDARY_OSC_SEL_BIT   8
`define PROT_PAGE_HI        6
`define PROT_PAGE_LO        0
// Deep-sleep word fields
`define DS_PIN_ONE_WAY_BIT  15
`define DS_I2C_ALT_BIT      14
`define DS_PLL_HI           13
`define DS_PLL_LO           10
`define DS_RTC_BAT_BIT      9
`define DS_SW_CTRL_BIT      8
`define DS_WDT_EN_BIT       7
`define DS_BOR_EN_BIT       6
`define DS_WDT_CLK_BIT      5
`define DS_PS_HI            4
`define DS_PS_LO            0
// Postscale exponent offset and window widths in eighths
`define DS_PS_OFFSET        6'h05
`define WIN_25_EIGHTHS      3'h2
`define WIN_37_EIGHTHS      3'h3
`define WIN_50_EIGHTHS      3'h4
`define WIN_75_EIGHTHS      3'h6
// Last program page index (7-bit) holding the words
`define LAST_PAGE           7'h7f
`define FIRST_PAGE          7'h00

`endif

/* rtl/config_decode_pkg.sv */
// Purpose: Types for the configuration word decoder
// Assumes: Constants come from config_decode_defs.svh
// Notes:   Enumerations of decoded modes
package config_decode_pkg;

    typedef enum logic [2:0] {
        OSC_FAST_RC, OSC_FAST_RC_PLL, OSC_PRIMARY, OSC_PRIMARY_PLL,
        OSC_SECONDARY, OSC_LOW_POWER_RC, OSC_RESERVED, OSC_FAST_RC_DIV
    } init_osc_type;

    typedef enum logic [1:0] {
        PRI_EXT_CLOCK, PRI_STD_CRYSTAL, PRI_HS_CRYSTAL, PRI_DISABLED
    } pri_mode_type;

    typedef enum logic [1:0] {
        WDT_CLK_LOW_POWER_RC_OSC, WDT_CLK_FAST_RC_31K, WDT_CLK_SECONDARY, WDT_CLK_SYSTEM
    } wdt_clk_type;

    typedef enum {
        LD_IDLE, LD_REQ, LD_DONE
    } load_state_type;

endpackage : config_decode_pkg

/* rtl/device_config_word_decode.sv */
// Purpose: Load the configuration words at reset and decode static settings
// Assumes: Flash read port answers in the same cycle as the request
// Notes:   Each word decodes as erased (all-ones) until its load cycle
//          Decodes are static levels; context inputs only steer the
//          watchdog clock, brown-out, deep-sleep, pin-select lock and pin-write, and config-page outputs
`timescale 1ns/1ps
`include "config_decode_defs.svh"

module device_config_word_decode
    import config_decode_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        rst_b_i,

    // Flash read port toward the packed word block
    output logic             flash_rd_o,
    output logic [1:0]       flash_idx_o,
    input  wire logic [23:0] flash_data_i,

    // Table-read port
    input  wire logic [1:0]  table_idx_i,
    output logic [23:0]      table_data_o,

    // Run-time context from consumers
    input  wire logic        window_mode_i,
    input  wire logic        sys_clk_is_low_power_rc_osc_i,
    input  wire logic        in_sleep_i,
    input  wire logic        in_deep_sleep_i,
    input  wire logic        deep_sleep_request_i,
    input  wire logic        pin_unlocked_i,
    input  wire logic        pin_lock_set_i,
    input  wire logic        pin_lock_clear_i,
    input  wire logic [6:0]  cfg_page_i,

    // Decoded settings; meaningless until config_valid_o rises
    output logic             config_valid_o,

    // Clock and oscillator settings
    output init_osc_type     initial_osc_select_o,
    output logic             clock_switch_en_o,
    output logic             fail_safe_monitor_en_o,
    output logic             two_speed_startup_en_o,
    output pri_mode_type     primary_osc_mode_o,
    output logic             clock_output_pin_en_o,
    output logic             primary_crystal_hs_o,
    output wdt_clk_type      watchdog_clock_source_o,
    output logic             brownout_en_o,
    output logic             battery_brownout_en_o,
    output logic             comparator_ref_pin_alt_o,
    output logic             converter_ref_pin_alt_o,

    // Protection settings
    output logic             segment_protect_en_o,
    output logic [6:0]       protect_low_page_o,
    output logic [6:0]       protect_high_page_o,
    output logic             config_page_protect_o,
    output logic [2:0]       watchdog_window_eighths_o,
    output logic             secondary_osc_select_o,

    // Pin, USB and deep-sleep settings
    output logic             pin_select_lock_o,
    output logic             pin_select_write_ok_o,
    output logic             second_i2c_pin_alt_o,
    output logic             usb_pll_en_o,
    output logic             usb_pll_reserved_o,
    output logic [3:0]       usb_pll_divisor_o,
    output logic             battery_rtc_run_o,
    output logic             deep_sleep_allowed_o,
    output logic             deep_sleep_watchdog_en_o,
    output logic             deep_sleep_watchdog_clk_o,
    output logic [5:0]       deep_sleep_watchdog_postscale_o
);

    ////////////////////////////////////////////////////////////////////////
    // One record holds all state: loader phase, word index, the three
    // stored words and the pin-select lock with its one-shot history.
    // Words start erased, as an unprogrammed part reads back.
    typedef struct packed {
        load_state_type state;
        logic [1:0]     idx;
        logic [23:0]    osc;
        logic [23:0]    prot;
        logic [23:0]    dslp;
        logic           lock;
        // Lock history lasts until the next reset
        logic           lock_used;
    } state_type;

    state_type state_reg;
    state_type state_next;

    ////////////////////////////////////////////////////////////////////////
    // Loader: walk words 1..3, one request per cycle, data in the same cycle
    // Zero-wait reads assumed; a slower store would need a ready input.
    // Once done the loader never re-arms: only a reset reloads the words.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg.state)
            LD_IDLE: begin
                state_next.state = LD_REQ;
                state_next.idx   = `CW_IDX_OSC;
            end

            LD_REQ: begin
                // Upper byte is not stored; it always reads back as ones
                unique case (state_reg.idx)
                    `CW_IDX_OSC:  state_next.osc  = {`CW_UPPER_ONES, flash_data_i[15:0]};
                    `CW_IDX_PROT: state_next.prot = {`CW_UPPER_ONES, flash_data_i[15:0]};
                    default:      state_next.dslp = {`CW_UPPER_ONES, flash_data_i[15:0]};
                endcase
                // Last word captured: decodes are final from the next cycle
                if (state_reg.idx == `CW_IDX_LAST) begin
                    state_next.state = LD_DONE;
                end else begin
                    state_next.idx = state_reg.idx + 2'h1;
                end
            end

            LD_DONE: begin
                state_next.state = LD_DONE;
            end
        endcase

        // Pin-select lock, policy from the deep-sleep word. Gated on the
        // loaded state so the policy bit is never read while still erased.
        if (state_reg.state == LD_DONE && pin_unlocked_i) begin
            if (state_reg.dslp[`DS_PIN_ONE_WAY_BIT]) begin
                if (pin_lock_set_i && !state_reg.lock_used) begin
                    state_next.lock      = 1'b1;
                    state_next.lock_used = 1'b1;
                end
            end else if (pin_lock_set_i) begin
                // Set wins over a clear in the same cycle
                state_next.lock = 1'b1;
            end else if (pin_lock_clear_i) begin
                state_next.lock = 1'b0;
            end
        end
    end

    // Data is captured at the end of the same cycle in which the address is issued
    // Request is a level for the whole loading phase, one index per cycle
    assign flash_rd_o  = (state_reg.state == LD_REQ);
    assign flash_idx_o = state_reg.idx;

    // Asynchronous clear restarts the loader from the first word
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg.state     <= LD_IDLE;
            state_reg.idx       <= 2'h0;
            state_reg.osc       <= `CW_ERASED;
            state_reg.prot      <= `CW_ERASED;
            state_reg.dslp      <= `CW_ERASED;
            state_reg.lock      <= 1'b0;
            state_reg.lock_used <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Table read
    // Index 0 has no word behind it here and reads erased
    always_comb begin
        unique case (table_idx_i)
            `CW_IDX_OSC:  table_data_o = state_reg.osc;
            `CW_IDX_PROT: table_data_o = state_reg.prot;
            `CW_IDX_DSLP: table_data_o = state_reg.dslp;
            default:      table_data_o = `CW_ERASED;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Oscillator word decode
    // Bit 15     two-speed start-up enable
    // Bit 14     battery-mode brown-out enable
    // Bit 13     watchdog clock mux enable
    // Bit 12     comparator reference pin alternate
    // Bit 11     converter reference pin alternate
    // Bits 10:8  initial oscillator select
    // Bits 7:6   clock switch and monitor
    // Bit 5      clock output pin function
    // Bits 4:3   watchdog clock source
    // Bit 2      reserved, ignored
    // Bits 1:0   primary oscillator mode

    // Short names for the multi-bit fields
    logic [1:0] cksm;
    logic [1:0] wsrc;
    assign cksm = state_reg.osc[`OSC_CKSM_HI:`OSC_CKSM_LO];
    assign wsrc = state_reg.osc[`OSC_WDT_SRC_HI:`OSC_WDT_SRC_LO];

    // Consumers ignore every decode below until this rises
    assign config_valid_o          = (state_reg.state == LD_DONE);
    assign initial_osc_select_o    = init_osc_type'(state_reg.osc[`OSC_INIT_HI:`OSC_INIT_LO]);
    assign clock_switch_en_o       = !cksm[1];
    assign fail_safe_monitor_en_o  = (cksm == 2'h0);
    assign two_speed_startup_en_o  = state_reg.osc[`OSC_TWO_SPEED_BIT];
    assign primary_osc_mode_o      = pri_mode_type'(state_reg.osc[`OSC_PRI_HI:`OSC_PRI_LO]);
    assign primary_crystal_hs_o    = (primary_osc_mode_o == PRI_HS_CRYSTAL);

    // Pin bit only matters with no crystal on the pins (modes 11 and 00)
    assign clock_output_pin_en_o   = (primary_osc_mode_o == PRI_DISABLED ||
                                      primary_osc_mode_o == PRI_EXT_CLOCK) &&
                                     state_reg.osc[`OSC_PIN_FUNC_BIT];

    assign battery_brownout_en_o   = state_reg.osc[`OSC_VBAT_BOR_BIT];
    assign comparator_ref_pin_alt_o = state_reg.osc[`OSC_CMP_REF_BIT];
    assign converter_ref_pin_alt_o = state_reg.osc[`OSC_ADC_REF_BIT];

    // Watchdog clock; consumers keep sleep/window context current
    // Limitation: the choice follows the context inputs without filtering,
    // so a consumer switching clocks must do its own glitch-free handover.
    always_comb begin
        if (!state_reg.osc[`OSC_WDT_MUX_BIT]) begin
            watchdog_clock_source_o = WDT_CLK_LOW_POWER_RC_OSC;
        end else begin
            unique case (wsrc)
                2'h3: watchdog_clock_source_o = WDT_CLK_LOW_POWER_RC_OSC;
                2'h2: watchdog_clock_source_o = (window_mode_i && !sys_clk_is_low_power_rc_osc_i && !in_sleep_i)
                                                ? WDT_CLK_FAST_RC_31K : WDT_CLK_LOW_POWER_RC_OSC;
                2'h1: watchdog_clock_source_o = WDT_CLK_SECONDARY;
                default: watchdog_clock_source_o = in_sleep_i ? WDT_CLK_LOW_POWER_RC_OSC : WDT_CLK_SYSTEM;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Protection word decode
    // Bit 15     end-page select
    // Bit 14     configuration page protect, active low
    // Bit 13     segment protect disable
    // Bit 12     main brown-out enable
    // Bit 11     reserved, ignored
    // Bits 10:9  watchdog window width
    // Bit 8      secondary oscillator select
    // Bit 7      reserved, ignored
    // Bits 6:0   boundary page

    // Short names for the page fields
    logic       end_page;
    logic [6:0] bound;
    assign end_page = state_reg.prot[`PROT_END_PAGE_BIT];
    assign bound    = state_reg.prot[`PROT_PAGE_HI:`PROT_PAGE_LO];

    // Bounds are inclusive page numbers for the enforcement path
    assign segment_protect_en_o  = !state_reg.prot[`PROT_DISABLE_BIT];
    assign protect_low_page_o    = end_page ? bound : `FIRST_PAGE;
    assign protect_high_page_o   = end_page ? `LAST_PAGE : bound;
    // Config page guarded on end-page select or a boundary on it, whatever the separate bit says
    assign config_page_protect_o = end_page || (bound == cfg_page_i) ||
                                   !state_reg.prot[`PROT_CFG_PAGE_BIT];
    assign secondary_osc_select_o = state_reg.prot[`PROT_SECONDARY_OSC_SEL_BIT];

    // Brown-out: main bit outside deep sleep, own bit inside
    // Battery-mode brown-out is a separate static enable above
    assign brownout_en_o = in_deep_sleep_i ? state_reg.dslp[`DS_BOR_EN_BIT]
                                           : state_reg.prot[`PROT_BOR_EN_BIT];

    // Width kept in eighths of the period so 37.5% stays exact
    always_comb begin
        unique case (state_reg.prot[`PROT_WIN_HI:`PROT_WIN_LO])
            2'h3:    watchdog_window_eighths_o = `WIN_25_EIGHTHS;
            2'h2:    watchdog_window_eighths_o = `WIN_37_EIGHTHS;
            2'h1:    watchdog_window_eighths_o = `WIN_50_EIGHTHS;
            default: watchdog_window_eighths_o = `WIN_75_EIGHTHS;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Deep-sleep word decode
    // Bit 15     one-way pin lock
    // Bit 14     second I2C pin alternate
    // Bits 13:10 USB PLL prescaler
    // Bit 9      battery timekeeping
    // Bit 8      deep-sleep software control
    // Bit 7      deep-sleep watchdog enable
    // Bit 6      deep-sleep brown-out enable
    // Bit 5      deep-sleep watchdog clock
    // Bits 4:0   deep-sleep watchdog postscaler

    // Short name for the prescaler field
    logic [3:0] pll;
    assign pll = state_reg.dslp[`DS_PLL_HI:`DS_PLL_LO];

    // Write permission needs both the unlock sequence and a clear lock
    assign pin_select_lock_o      = state_reg.lock;
    assign pin_select_write_ok_o  = pin_unlocked_i && !state_reg.lock;

    assign second_i2c_pin_alt_o   = state_reg.dslp[`DS_I2C_ALT_BIT];
    assign usb_pll_en_o           = (pll != 4'hf);
    assign usb_pll_reserved_o     = pll[3] && (pll != 4'hf);

    // Divisor 0 marks no usable division: off or reserved code
    always_comb begin
        unique case (pll)
            4'h7:    usb_pll_divisor_o = 4'hc;
            4'h6:    usb_pll_divisor_o = 4'h8;
            4'h5:    usb_pll_divisor_o = 4'h6;
            4'h4:    usb_pll_divisor_o = 4'h5;
            4'h3:    usb_pll_divisor_o = 4'h4;
            4'h2:    usb_pll_divisor_o = 4'h3;
            4'h1:    usb_pll_divisor_o = 4'h2;
            4'h0:    usb_pll_divisor_o = 4'h1;
            default: usb_pll_divisor_o = 4'h0;
        endcase
    end

    assign battery_rtc_run_o         = state_reg.dslp[`DS_RTC_BAT_BIT];
    // A software request counts only when the word permits deep sleep
    assign deep_sleep_allowed_o      = state_reg.dslp[`DS_SW_CTRL_BIT] &&
                                       deep_sleep_request_i;
    assign deep_sleep_watchdog_en_o  = state_reg.dslp[`DS_WDT_EN_BIT];
    assign deep_sleep_watchdog_clk_o = state_reg.dslp[`DS_WDT_CLK_BIT];
    // Exponent of two for the ratio, 5..36
    // The ratio itself needs 37 bits, so only the exponent leaves here
    assign deep_sleep_watchdog_postscale_o =
        {1'b0, state_reg.dslp[`DS_PS_HI:`DS_PS_LO]} + `DS_PS_OFFSET;

endmodule : device_config_word_decode

/* verification/config_decode_props.sv */
// Purpose: Concurrent checks on the configuration word decoder ports
// Assumes: Table view is compared while the bench holds table_idx_i steady
// Notes:   Bound into every instance of the decoder
`timescale 1ns/1ps
module config_decode_props
    import config_decode_pkg::*;
(
    input wire logic         clock_i,
    input wire logic         rst_b_i,
    input wire logic         flash_rd_o,
    input wire logic [1:0]   flash_idx_o,
    input wire logic [1:0]   table_idx_i,
    input wire logic [23:0]  table_data_o,
    input wire logic         pin_unlocked_i,
    input wire logic         pin_lock_set_i,
    input wire logic         config_valid_o,
    input wire init_osc_type initial_osc_select_o,
    input wire logic         clock_switch_en_o,
    input wire logic         fail_safe_monitor_en_o,
    input wire pri_mode_type primary_osc_mode_o,
    input wire logic         clock_output_pin_en_o,
    input wire logic         pin_select_lock_o,
    input wire logic         usb_pll_reserved_o,
    input wire logic [3:0]   usb_pll_divisor_o,
    input wire logic [5:0]   deep_sleep_watchdog_postscale_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_fetch_first;
        flash_rd_o && flash_idx_o == 2'h1;
    endsequence
    sequence s_fetch_rest;
        flash_rd_o && flash_idx_o == 2'h2 ##1 flash_rd_o && flash_idx_o == 2'h3 ##1 !flash_rd_o && config_valid_o;
    endsequence
    property p_load_walk; s_fetch_first |=> s_fetch_rest; endproperty
    a_load_walk: assert property (p_load_walk) else $error("load walk out of order");
    // Any decode moving after load would reach consumers as a glitch
    property p_static;
        config_valid_o |=> config_valid_o && $stable({initial_osc_select_o, primary_osc_mode_o, usb_pll_divisor_o});
    endproperty
    a_static: assert property (p_static) else $error("decode changed while loaded");
    property p_osc; table_idx_i == 2'h1 |-> initial_osc_select_o == table_data_o[10:8]; endproperty
    a_osc: assert property (p_osc) else $error("initial oscillator decode wrong");
    property p_cksm;
        table_idx_i == 2'h1 |-> clock_switch_en_o == !table_data_o[7]
            && fail_safe_monitor_en_o == (table_data_o[7:6] == 2'h0);
    endproperty
    a_cksm: assert property (p_cksm) else $error("clock switch decode wrong");
    property p_pri; table_idx_i == 2'h1 |-> primary_osc_mode_o == table_data_o[1:0]; endproperty
    a_pri: assert property (p_pri) else $error("primary mode decode wrong");
    property p_cko;
        table_idx_i == 2'h1 && table_data_o[0] == table_data_o[1] |-> clock_output_pin_en_o == table_data_o[5];
    endproperty
    a_cko: assert property (p_cko) else $error("clock output pin decode wrong");
    property p_upper; table_data_o[23:16] == 8'hff; endproperty
    a_upper: assert property (p_upper) else $error("upper byte not ones");
    property p_pll;
        table_idx_i == 2'h3 |-> usb_pll_reserved_o == (table_data_o[13] && table_data_o[12:10] != 3'h7)
            && (!table_data_o[13] || usb_pll_divisor_o == 4'h0);
    endproperty
    a_pll: assert property (p_pll) else $error("usb prescaler decode wrong");
    property p_ps; table_idx_i == 2'h3 |-> deep_sleep_watchdog_postscale_o == table_data_o[4:0] + 6'h05; endproperty
    a_ps: assert property (p_ps) else $error("postscale exponent wrong");
    property p_lock; config_valid_o && pin_unlocked_i && pin_lock_set_i |=> pin_select_lock_o; endproperty
    a_lock: assert property (p_lock) else $error("pin lock not set");
endmodule : config_decode_props
bind device_config_word_decode config_decode_props u_props (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .flash_rd_o(flash_rd_o), .flash_idx_o(flash_idx_o),
    .table_idx_i(table_idx_i), .table_data_o(table_data_o), .pin_unlocked_i(pin_unlocked_i),
    .pin_lock_set_i(pin_lock_set_i), .config_valid_o(config_valid_o), .initial_osc_select_o(initial_osc_select_o),
    .clock_switch_en_o(clock_switch_en_o), .fail_safe_monitor_en_o(fail_safe_monitor_en_o),
    .primary_osc_mode_o(primary_osc_mode_o), .clock_output_pin_en_o(clock_output_pin_en_o),
    .pin_select_lock_o(pin_select_lock_o), .usb_pll_reserved_o(usb_pll_reserved_o),
    .usb_pll_divisor_o(usb_pll_divisor_o), .deep_sleep_watchdog_postscale_o(deep_sleep_watchdog_postscale_o)
);

/* verification/device_config_word_decode_tb.sv */
// Purpose: Self-checking bench for the configuration word decoder
// Assumes: Flash answers with the word for the index seen at the last falling edge
// Notes:   Ten reloads sweep the field codes; context inputs swept after each
`timescale 1ns/1ps
module device_config_word_decode_tb;
    import config_decode_pkg::*;
    logic         clock_i, rst_b_i, rd, win, low_power_rc_osc, slp, dslp, dreq, unl, lset, lclr, valid;
    logic         cse, fsm, tss, cko, hs, bor, vbor, cref, aref, cpp, lock, pen, pres, rtc, dsa, dwe, dwc;
    logic [1:0]   idx, tidx;
    logic [2:0]   weig, b;
    logic [3:0]   pdiv, pll;
    logic [4:0]   ps;
    logic [5:0]   pscl;
    logic [6:0]   lo, hi, pg, cpg;
    logic         sen, sos, wok, i2c;
    logic [23:0]  fdat, tdat, w2, w3, w4;
    logic [23:0]  words [0:3];
    init_osc_type osc;
    pri_mode_type pri;
    wdt_clk_type  wsrc;
    int           num_errors, n_tests;
    logic [2:0]   wtab [0:3] = '{3'h6, 3'h4, 3'h3, 3'h2};
    logic [3:0]   dtab [0:7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'hc};

    device_config_word_decode uut (
        .clock_i(clock_i), .rst_b_i(rst_b_i), .flash_rd_o(rd), .flash_idx_o(idx), .flash_data_i(fdat),
        .table_idx_i(tidx), .table_data_o(tdat), .window_mode_i(win), .sys_clk_is_low_power_rc_osc_i(low_power_rc_osc),
        .in_sleep_i(slp), .in_deep_sleep_i(dslp), .deep_sleep_request_i(dreq), .pin_unlocked_i(unl),
        .pin_lock_set_i(lset), .pin_lock_clear_i(lclr), .cfg_page_i(cpg), .config_valid_o(valid),
        .initial_osc_select_o(osc), .clock_switch_en_o(cse), .fail_safe_monitor_en_o(fsm),
        .two_speed_startup_en_o(tss), .primary_osc_mode_o(pri), .clock_output_pin_en_o(cko),
        .primary_crystal_hs_o(hs), .watchdog_clock_source_o(wsrc), .brownout_en_o(bor),
        .battery_brownout_en_o(vbor), .comparator_ref_pin_alt_o(cref), .converter_ref_pin_alt_o(aref),
        .segment_protect_en_o(sen), .protect_low_page_o(lo), .protect_high_page_o(hi),
        .config_page_protect_o(cpp), .watchdog_window_eighths_o(weig), .secondary_osc_select_o(sos),
        .pin_select_lock_o(lock), .pin_select_write_ok_o(wok), .second_i2c_pin_alt_o(i2c), .usb_pll_en_o(pen),
        .usb_pll_reserved_o(pres), .usb_pll_divisor_o(pdiv), .battery_rtc_run_o(rtc),
        .deep_sleep_allowed_o(dsa), .deep_sleep_watchdog_en_o(dwe), .deep_sleep_watchdog_clk_o(dwc),
        .deep_sleep_watchdog_postscale_o(pscl)
    );
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end
    always @(negedge clock_i) fdat <= words[idx];
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic end_of_test();
        if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    task automatic load();
        @(negedge clock_i);
        rst_b_i = 1'b0;
        tidx = 2'h1;
        repeat (2) @(negedge clock_i);
        chk("reset_view", 24'hffffff, tdat);
        chk("reset_flags", 2'h0, {valid, lock});
        rst_b_i = 1'b1;
        for (int k = 0; k < 8 && valid !== 1'b1; k++) @(negedge clock_i);
        chk("valid", 1'b1, valid);
    endtask : load
    task automatic pulse(input logic s, input logic cl);
        @(negedge clock_i);
        lset = s;
        lclr = cl;
        @(negedge clock_i);
        lset = 1'b0;
        lclr = 1'b0;
    endtask : pulse
    function automatic wdt_clk_type wexp(input logic [23:0] w, input logic [2:0] x);
        if (!w[13]) return WDT_CLK_LOW_POWER_RC_OSC;
        case (w[4:3])
            2'h3:    return WDT_CLK_LOW_POWER_RC_OSC;
            2'h2:    return (x[2] && !x[1] && !x[0]) ? WDT_CLK_FAST_RC_31K : WDT_CLK_LOW_POWER_RC_OSC;
            2'h1:    return WDT_CLK_SECONDARY;
            default: return x[0] ? WDT_CLK_LOW_POWER_RC_OSC : WDT_CLK_SYSTEM;
        endcase
    endfunction : wexp
    // A hang anywhere costs at most this span; the full run needs far less
    initial begin
        #400000;
        num_errors++;
        end_of_test();
    end
    initial begin
        {rst_b_i, win, low_power_rc_osc, slp, dslp, dreq, unl, lset, lclr, tidx, fdat} = '0;
        words = '{default: 24'hffffff};
        repeat (16) @(negedge clock_i);
        for (int i = 0; i < 10; i++) begin
            b = i[2:0];
            pg = (i == 6) ? 7'h7f : {b, 4'h3};
            cpg = (i == 4) ? pg : 7'h7f;
            pll = (i < 8) ? i[3:0] : ((i == 8) ? 4'hf : 4'hc);
            ps = (i == 9) ? 5'h1f : {2'h0, b};
            w2 = {8'h00, b[0], b[1], (i != 7), b[0], b[1], b, b[1:0], b[2], b[1:0], 1'b0, b[1:0]};
            w3 = {8'h00, b[0], 1'b1, b[2], b[1], 1'b1, b[1:0], b[0], 1'b1, pg};
            w4 = {8'h00, b[0], b[1], pll, b[0], b[1], b[2], !b[0], b[1], ps};
            words[1] = w2;
            words[2] = w3;
            words[3] = w4;
            load();
            for (int j = 0; j < 4; j++) begin
                tidx = j[1:0];
                #1 chk("table", (j == 0) ? 24'hffffff : {8'hff, words[j][15:0]}, tdat);
            end
            chk("init_osc", b, osc);
            chk("switch_monitor", {!b[1], b[1:0] == 2'h0}, {cse, fsm});
            chk("two_speed", b[0], tss);
            chk("primary", {b[1:0], b[1:0] == 2'h2}, {pri, hs});
            if (b[0] == b[1]) chk("clock_out", b[2], cko);
            chk("battery_bor_refs", {b[1], b[0], b[1]}, {vbor, cref, aref});
            chk("pages", b[0] ? {pg, 7'h7f} : {7'h00, pg}, {lo, hi});
            chk("cfg_page", b[0] | (pg == cpg), cpp);
            chk("segment_misc", {!b[2], b[0], b[1]}, {sen, sos, i2c});
            chk("window", wtab[b[1:0]], weig);
            if (i < 8) chk("pll", {2'h2, dtab[i]}, {pen, pres, pdiv});
            else chk("pll", {(i == 9), 4'h0}, {pres, pdiv});
            if (i == 8) chk("pll_off", 1'b0, pen);
            chk("deep_sleep", {b[0], b[2], b[1]}, {rtc, dwe, dwc});
            chk("postscale", ps + 6'h05, pscl);
            for (int c = 0; c < 16; c++) begin
                @(negedge clock_i);
                {win, low_power_rc_osc, slp, dslp} = c[3:0];
                dreq = c[2];
                #1 chk("wdt_source", wexp(w2, c[3:1]), wsrc);
                chk("brownout", c[0] ? !b[0] : b[1], bor);
                chk("ds_allowed", b[1] & c[2], dsa);
            end
            unl = 1'b0;
            pulse(1'b1, 1'b0);
            chk("lock_refused", 1'b0, lock);
            unl = 1'b1;
            pulse(1'b1, 1'b0);
            chk("lock_set", 1'b1, lock);
            chk("write_ok_locked", 1'b0, wok);
            pulse(1'b0, 1'b1);
            chk("lock_clear", b[0], lock);
            chk("write_ok_clear", !b[0], wok);
            pulse(1'b1, 1'b0);
            chk("lock_again", 1'b1, lock);
        end
        end_of_test();
    end
endmodule : device_config_word_decode_tb
